// ==== hdl/sar_adc_controller.sv ====
// control logic of the eight-input 10-bit successive-approximation converter
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps

module sar_adc_controller
  import sar_adc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire bus_req_t bus_in,
  output logic [7:0] rdata_out,
  output logic bus_wait_out,
  input wire logic comparator_in,
  output afe_ctrl_t afe_out,
  output logic conv_done_irq_out,
  output logic conv_active_out,
  output logic conv_waiting_out
);

  state_t q;
  state_t d;

  // clocks in one slot for a conversion-time code; prohibited codes fall
  // back to the slowest setting
  function automatic logic [CNT_W-1:0] slot_clks(input logic [2:0] code);
    int clks;
    case (code)
      3'h0: clks = CONV_CLKS_000;
      3'h1: clks = CONV_CLKS_001;
      3'h2: clks = CONV_CLKS_010;
      3'h4: clks = CONV_CLKS_100;
      3'h5: clks = CONV_CLKS_101;
      3'h6: clks = CONV_CLKS_110;
      default: clks = CONV_CLKS_000;
    endcase
    return CNT_W'(clks / SLOTS_PER_CONV);
  endfunction : slot_clks

  function automatic logic is_addr(input logic [15:0] a,
                                   input logic [15:0] ref_a);
    return a == ref_a;
  endfunction : is_addr

  logic run;
  logic [2:0] time_code;
  logic [CNT_W-1:0] slot_len;
  logic [9:0] bit_mask;
  logic [9:0] decided;
  logic pf_hit;
  logic [7:0] wmask_mode;

  assign run = q.converter_mode[MODE_CONV_RUN_BIT];
  assign time_code = q.converter_mode[MODE_TIME_SEL_LSB +: 3];
  assign slot_len = slot_clks(time_code);
  assign bit_mask = 10'h001 << q.bit_idx;
  assign wmask_mode = MODE_WRITE_MASK;

  // keep the trial bit only when the input is at or above the tap
  always_comb begin
    if (q.cmp_sync) begin
      decided = q.approx_shift_reg;
    end else begin
      decided = q.approx_shift_reg & ~bit_mask;
    end
  end

  // upper eight result bits against the threshold, polarity selects side
  always_comb begin
    if (q.powerfail_polarity) begin
      pf_hit = decided[9:2] < q.powerfail_threshold;
    end else begin
      pf_hit = decided[9:2] >= q.powerfail_threshold;
    end
  end

  always_comb begin
    d = q;
    d.conv_done_irq = 1'b0;
    // comparator passes two flops before use
    d.cmp_meta = comparator_in;
    d.cmp_sync = q.cmp_meta;

    // register writes
    if (bus_in.wr) begin
      if (is_addr(bus_in.addr, ADDR_CONVERTER_MODE)) begin
        d.converter_mode = bus_in.wdata & wmask_mode;
      end
      if (is_addr(bus_in.addr, ADDR_CHANNEL_SELECT)) begin
        d.channel_select = bus_in.wdata[2:0] & CHANNEL_WRITE_MASK[2:0];
      end
      if (is_addr(bus_in.addr, ADDR_POWERFAIL_MODE)) begin
        d.powerfail_compare_on = bus_in.wdata[PF_COMPARE_ON_BIT];
        d.powerfail_polarity = bus_in.wdata[PF_POLARITY_BIT];
      end
      if (is_addr(bus_in.addr, ADDR_POWERFAIL_THRESHOLD)) begin
        d.powerfail_threshold = bus_in.wdata;
      end
    end

    // register reads, data stand in the following cycle
    d.rdata = 8'h00;
    if (bus_in.rd) begin
      if (is_addr(bus_in.addr, ADDR_CONVERTER_MODE)) begin
        d.rdata = q.converter_mode;
      end else if (is_addr(bus_in.addr, ADDR_CHANNEL_SELECT)) begin
        d.rdata = {5'h00, q.channel_select};
      end else if (is_addr(bus_in.addr, ADDR_POWERFAIL_MODE)) begin
        d.rdata = {q.powerfail_compare_on, q.powerfail_polarity, 6'h00};
      end else if (is_addr(bus_in.addr, ADDR_POWERFAIL_THRESHOLD)) begin
        d.rdata = q.powerfail_threshold;
      end else if (is_addr(bus_in.addr, ADDR_RESULT_HI)) begin
        d.rdata = q.conv_result[9:2];
      end else if (is_addr(bus_in.addr, ADDR_RESULT_LO)) begin
        d.rdata = {q.conv_result[1:0], 6'h00};
      end else begin
        d.rdata = 8'h00;
      end
    end

    // conversion sequencer
    case (q.phase)
      PH_IDLE: begin
        if (run) begin
          d.phase = PH_SAMPLE;
          d.slot_cnt = CNT_W'(slot_len * SAMPLE_SLOTS - 1);
        end
      end
      PH_SAMPLE: begin
        if (!run) begin
          d.phase = PH_IDLE;
        end else if (q.slot_cnt == '0) begin
          d.phase = PH_DECIDE;
          d.bit_idx = 4'h9;
          d.approx_shift_reg = 10'h200;
          d.slot_cnt = CNT_W'(slot_len - 1);
        end else begin
          d.slot_cnt = q.slot_cnt - 1'b1;
        end
      end
      PH_DECIDE: begin
        if (!run) begin
          d.phase = PH_IDLE;
        end else if (q.slot_cnt != '0) begin
          d.slot_cnt = q.slot_cnt - 1'b1;
        end else if (q.bit_idx == 4'h0) begin
          d.approx_shift_reg = decided;
          d.conv_result = decided;
          if (q.powerfail_compare_on) begin
            d.conv_done_irq = pf_hit;
          end else begin
            d.conv_done_irq = 1'b1;
          end
          // start the next conversion with no software action
          d.phase = PH_SAMPLE;
          d.slot_cnt = CNT_W'(slot_len * SAMPLE_SLOTS - 1);
        end else begin
          d.approx_shift_reg = decided | (bit_mask >> 1);
          d.bit_idx = q.bit_idx - 1'b1;
          d.slot_cnt = CNT_W'(slot_len - 1);
        end
      end
      default: begin
        d.phase = PH_IDLE;
      end
    endcase

    if (!nrst_in) begin
      d.phase = PH_IDLE;
      d.converter_mode = MODE_RESET;
      d.channel_select = CHANNEL_RESET;
      d.powerfail_compare_on = 1'b0;
      d.powerfail_polarity = 1'b0;
      d.powerfail_threshold = THRESHOLD_RESET;
      d.approx_shift_reg = RESULT_RESET;
      d.bit_idx = 4'h0;
      d.slot_cnt = '0;
      d.conv_result = RESULT_RESET;
      d.conv_done_irq = 1'b0;
      d.rdata = 8'h00;
      d.cmp_meta = 1'b0;
      d.cmp_sync = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    q <= d;
  end

  assign rdata_out = q.rdata;
  assign conv_done_irq_out = q.conv_done_irq;

  // wait cycle flag for accesses that stall the processor
  assign bus_wait_out = (bus_in.wr &&
                         (is_addr(bus_in.addr, ADDR_CONVERTER_MODE) ||
                          is_addr(bus_in.addr, ADDR_CHANNEL_SELECT) ||
                          is_addr(bus_in.addr, ADDR_POWERFAIL_MODE) ||
                          is_addr(bus_in.addr, ADDR_POWERFAIL_THRESHOLD)))
                        || (bus_in.rd &&
                         (is_addr(bus_in.addr, ADDR_RESULT_HI) ||
                          is_addr(bus_in.addr, ADDR_RESULT_LO)));

  // operating status from the two control bits
  assign conv_active_out = run;
  assign conv_waiting_out = !run &&
                            q.converter_mode[MODE_REF_GEN_BIT];

  // analog front end controls, all from flops
  assign afe_out.sampling = (q.phase == PH_SAMPLE);
  assign afe_out.hold = (q.phase == PH_DECIDE);
  assign afe_out.channel = q.channel_select;
  assign afe_out.tap = q.approx_shift_reg;
  assign afe_out.ref_gen_on = q.converter_mode[MODE_REF_GEN_BIT];

endmodule : sar_adc_controller

// ==== hdl/sar_adc_pkg.sv ====
// constants and carrier types for the successive-approximation converter
package sar_adc_pkg;

  // register addresses
  localparam logic [15:0] ADDR_RESULT_LO = 16'hff08;
  localparam logic [15:0] ADDR_RESULT_HI = 16'hff09;
  localparam logic [15:0] ADDR_CONVERTER_MODE = 16'hff28;
  localparam logic [15:0] ADDR_CHANNEL_SELECT = 16'hff29;
  localparam logic [15:0] ADDR_POWERFAIL_MODE = 16'hff2a;
  localparam logic [15:0] ADDR_POWERFAIL_THRESHOLD = 16'hff2b;

  // converter_mode fields
  localparam int MODE_CONV_RUN_BIT = 7;
  localparam int MODE_TIME_SEL_LSB = 3;
  localparam int MODE_REF_GEN_BIT = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'hb9;
  // channel_select and powerfail_mode fields
  localparam logic [7:0] CHANNEL_WRITE_MASK = 8'h07;
  localparam int PF_COMPARE_ON_BIT = 7;
  localparam int PF_POLARITY_BIT = 6;
  localparam logic [7:0] PF_WRITE_MASK = 8'hc0;

  // values after reset
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [2:0] CHANNEL_RESET = 3'h0;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  // result width and the zero padding below it
  localparam int RESULT_BITS = 10;
  localparam int RESULT_PAD = 6;

  // one conversion is twelve equal slots: two for sampling, ten decisions
  localparam int SLOTS_PER_CONV = 12;
  localparam int SAMPLE_SLOTS = 2;
  localparam int CONV_CLKS_000 = 288;
  localparam int CONV_CLKS_001 = 240;
  localparam int CONV_CLKS_010 = 192;
  localparam int CONV_CLKS_100 = 144;
  localparam int CONV_CLKS_101 = 120;
  localparam int CONV_CLKS_110 = 96;
  localparam int CNT_W = 6;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_SAMPLE = 3'h2,
    PH_DECIDE = 3'h4
  } phase_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic sampling;
    logic hold;
    logic [2:0] channel;
    logic [9:0] tap;
    logic ref_gen_on;
  } afe_ctrl_t;

  typedef struct packed {
    phase_t phase;
    logic [7:0] converter_mode;
    logic [2:0] channel_select;
    logic powerfail_compare_on;
    logic powerfail_polarity;
    logic [7:0] powerfail_threshold;
    logic [9:0] approx_shift_reg;
    logic [3:0] bit_idx;
    logic [CNT_W-1:0] slot_cnt;
    logic [9:0] conv_result;
    logic conv_done_irq;
    logic [7:0] rdata;
    logic cmp_meta;
    logic cmp_sync;
  } state_t;

endpackage : sar_adc_pkg

// ==== bench/sar_adc_properties.sv ====
// port checker for the converter controller
`timescale 1ns/1ps
module sar_adc_checker
  import sar_adc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire bus_req_t bus_in,
  input wire logic bus_wait_out,
  input wire afe_ctrl_t afe_out,
  input wire logic conv_done_irq_out,
  input wire logic conv_active_out,
  input wire logic conv_waiting_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  mode_write_a: assert property (
    bus_in.wr && bus_in.addr == ADDR_CONVERTER_MODE |=>
    conv_active_out == $past(bus_in.wdata[7]) &&
    afe_out.ref_gen_on == $past(bus_in.wdata[0]))
    else $error("mode write not applied");
  conv_waiting_a: assert property (
    conv_waiting_out == (!conv_active_out && afe_out.ref_gen_on))
    else $error("waiting flag wrong");
  sample_start_a: assert property (
    $rose(conv_active_out) |=> afe_out.sampling && !afe_out.hold)
    else $error("no sampling after start");
  first_trial_a: assert property (
    $rose(afe_out.hold) |-> afe_out.tap == 10'h200 && !afe_out.sampling)
    else $error("first trial not top bit");
  slot_len_a: assert property (
    afe_out.hold && $changed(afe_out.tap) |=>
    (!afe_out.hold || $stable(afe_out.tap))[*7])
    else $error("bit slot too short");
  done_irq_a: assert property (
    conv_done_irq_out |-> $past(afe_out.hold) ##1
    (afe_out.sampling || !conv_active_out))
    else $error("done pulse not after hold");
  stop_abort_a: assert property (
    $fell(conv_active_out) |=> (!conv_done_irq_out)[*2] ##0
    (!afe_out.hold && !afe_out.sampling))
    else $error("stop did not abort quietly");
  mode_wait_a: assert property (
    bus_in.wr && bus_in.addr == ADDR_CONVERTER_MODE |-> bus_wait_out)
    else $error("no wait on mode write");
endmodule : sar_adc_checker

bind sar_adc_controller sar_adc_checker chk (.ref_clk_in, .nrst_in,
  .bus_in, .bus_wait_out, .afe_out, .conv_done_irq_out,
  .conv_active_out, .conv_waiting_out);

// ==== bench/afe_model.sv ====
// analog front end: sample-hold, tap selector and comparator
`timescale 1ns/1ps
module afe_model
  import sar_adc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire afe_ctrl_t afe_in,
  input wire logic [79:0] vin_in,
  output logic comparator_out
);
  logic [9:0] held;
  initial begin
    held = 10'h000;
    comparator_out = 1'b0;
  end
  always @(posedge ref_clk_in) begin
    if (afe_in.sampling) begin
      held <= vin_in[afe_in.channel*10 +: 10];
    end
    if (afe_in.hold) begin
      comparator_out <= held >= afe_in.tap;
    end else begin
      comparator_out <= !comparator_out;
    end
  end
endmodule : afe_model

// ==== bench/testbench.sv ====
// self-checking bench for the converter controller
`timescale 1ns/1ps
module testbench import sar_adc_pkg::*;;
  logic ref_clk_in;
  logic nrst_in;
  bus_req_t bus_in;
  logic [7:0] rdata_out;
  logic cmp;
  afe_ctrl_t afe;
  logic irq;
  logic act;
  logic wt;
  logic [79:0] vin;
  logic [9:0] e;
  int fails;
  int tests_run;
  int cyc;
  int n;
  int codes[6] = '{0, 1, 2, 4, 5, 6};
  // every code is shorter than the analog minimum at this clock; the model
  // settles at once, so the timing window itself is not exercised
  int clks[6] = '{288, 240, 192, 144, 120, 96};
  logic [7:0] powerfail_mode[4] = '{8'h80, 8'h80, 8'hc0, 8'hc0};
  logic [7:0] thr[4] = '{8'ha9, 8'haa, 8'haa, 8'ha9};
  logic hit[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  sar_adc_controller dut (.ref_clk_in, .nrst_in, .bus_in, .rdata_out,
    .bus_wait_out(), .comparator_in(cmp), .afe_out(afe),
    .conv_done_irq_out(irq), .conv_active_out(act),
    .conv_waiting_out(wt));
  afe_model fe (.ref_clk_in, .afe_in(afe), .vin_in(vin),
    .comparator_out(cmp));
  task automatic check(input logic [15:0] s, input logic [15:0] x);
    tests_run++;
    if (s !== x) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, x);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    bus_in <= '{a, v, 1'b1, 1'b0};
    @(posedge ref_clk_in);
    bus_in <= '0;
  endtask : wr
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] x);
    @(posedge ref_clk_in);
    bus_in <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_in);
    bus_in <= '0;
    #1;
    check(16'(rdata_out), 16'(x));
  endtask : rd_chk
  task automatic wait_irq(input int lim, output int k);
    k = 0;
    do begin
      @(posedge ref_clk_in);
      #1;
      k++;
    end while (irq !== 1'b1 && k < lim);
  endtask : wait_irq
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    nrst_in = 1'b0;
    bus_in = '0;
    vin = {10'h3ff, 10'h001, 10'h2aa, 10'h155, 10'h200, 10'h1ff,
      10'h0f0, 10'h2a4};
    repeat (2) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    rd_chk(ADDR_CONVERTER_MODE, 8'h00);
    rd_chk(ADDR_CHANNEL_SELECT, 8'h00);
    rd_chk(16'hff30, 8'h00);
    wr(ADDR_CONVERTER_MODE, 8'h7e);
    rd_chk(ADDR_CONVERTER_MODE, 8'h38);
    wr(ADDR_CONVERTER_MODE, 8'h01);
    #1;
    check(16'(wt), 16'h0001);
    repeat (560) @(posedge ref_clk_in);
    $display("register test done");
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CHANNEL_SELECT, 8'(i));
      wr(ADDR_CONVERTER_MODE, 8'h81 | 8'(codes[i] << 3));
      wait_irq(600, n);
      wait_irq(600, n);
      check(16'(n), 16'(clks[i]));
      e = vin[i*10 +: 10];
      rd_chk(ADDR_RESULT_HI, e[9:2]);
      rd_chk(ADDR_RESULT_LO, {e[1:0], 6'h00});
      wr(ADDR_CONVERTER_MODE, 8'h01);
    end
    $display("conversion test done");
    wr(ADDR_CHANNEL_SELECT, 8'h00);
    for (int j = 0; j < 4; j++) begin
      wr(ADDR_POWERFAIL_MODE, powerfail_mode[j]);
      wr(ADDR_POWERFAIL_THRESHOLD, thr[j]);
      rd_chk(ADDR_POWERFAIL_THRESHOLD, thr[j]);
      wr(ADDR_CONVERTER_MODE, 8'hb1);
      wait_irq(250, n);
      check(16'(n < 250), 16'(hit[j]));
      wr(ADDR_CONVERTER_MODE, 8'h01);
    end
    wr(ADDR_POWERFAIL_MODE, 8'h00);
    // new level on the selected input, so a leaked partial result would show
    vin[9:0] <= 10'h155;
    $display("power-fail test done");
    wr(ADDR_CONVERTER_MODE, 8'hb1);
    repeat (40) @(posedge ref_clk_in);
    wr(ADDR_CONVERTER_MODE, 8'h01);
    wait_irq(300, n);
    check(16'(n), 16'd300);
    rd_chk(ADDR_RESULT_HI, 8'ha9);
    $display("abort test done");
    report_and_stop();
  end
endmodule : testbench
